// ==== dllwl_pkg.sv ====
/*
 * Package for the DRAM DLL mode and write leveling block: command codes,
 * mode register bit positions, latency values and packed pin groups.
 * Assumes a single system clock domain; pins arrive asynchronously.
 */
// Functional notes
// - no-operation registers nothing, ongoing work continues
// - deselect ignores command inputs, work completes
// - register one bit A0 set disables DLL
// - DLL-off supports read/write latency six only
// - DLL-off read strobe starts one clock earlier
// - device ignores clock after clock-stop entry delay
// - register one bit A7 enters write leveling
// - register one bit A12 disables data outputs
// - leveling ODT switches only strobe termination
// - strobe rising edge samples clock onto data
// - each byte lane leveled by its own strobe
// - feedback on lane bit zero, others driven low
package dllwl_pkg;
    localparam int DQ_W = 16;
    localparam int ADDR_W = 14;
    localparam int LANE_W = 8;
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_NO_OP = 3'h7;
    localparam logic [2:0] BA_MODE_ZERO = 3'h0;
    localparam logic [2:0] BA_MODE_ONE = 3'h1;
    localparam int MODE1_DLL_OFF_BIT = 0;
    localparam int MODE1_LEVEL_BIT = 7;
    localparam int MODE1_QOFF_BIT = 12;
    localparam int MODE0_DLL_RESET_BIT = 8;
    localparam logic [3:0] DLL_OFF_CL = 4'h6;
    localparam logic [3:0] DLL_OFF_CWL = 4'h6;
    localparam logic [3:0] AL_RST = 4'h0;
    localparam logic [3:0] CL_RST = 4'h6;
    localparam int CLK_PERIOD_NS = 40;
    localparam int CLK_STOP_NS = 10;
    localparam logic [3:0] CLK_STOP_CYC =
        4'((CLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } dllwl_cmd_t;
    typedef struct packed {
        logic [2:0] bank;
        logic [ADDR_W-1:0] addr;
    } dllwl_addr_t;
    typedef enum {ST_IDLE, ST_SELF_REF, ST_CLK_DONT_CARE, ST_POWER_DOWN} dllwl_pwr_t;
endpackage

// ==== dllwl_core.sv ====
/*
 * DRAM-side DLL mode and write leveling logic: decodes commands sampled on
 * the memory clock rising edges, keeps mode register one state, power state, read
 * strobe start timing and the leveling feedback on the data bits.
 * Assumes the memory clock, strobes, command pins and ODT are asynchronous
 * to CLK_SYS and much slower, so they are synchronised and edge-detected.
 */
`timescale 1ns/1ps
module dllwl_core
(
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic MEM_CK,
    input wire logic MEM_CKE,
    input wire dllwl_pkg::dllwl_cmd_t MEM_CMD,
    input wire dllwl_pkg::dllwl_addr_t MEM_ADDR,
    input wire logic MEM_ODT,
    input wire logic MEM_LDQS,
    input wire logic MEM_UDQS,
    output logic [dllwl_pkg::DQ_W-1:0] DQ_OUT,
    output logic [dllwl_pkg::DQ_W-1:0] DQ_OE_N,
    output logic DQS_TERM_ON,
    output logic DQ_TERM_ON,
    output logic DLL_OFF,
    output logic LEVEL_MODE,
    output logic QOFF,
    output logic DLL_RESET,
    output logic [3:0] READ_LAT,
    output logic READ_STROBE_START,
    output logic CLK_IGNORED
);
    import dllwl_pkg::*;

    // two-stage synchronisers; stage one is read only by stage two
    logic [8:0] s1_r;
    logic [8:0] s2_r;
    logic [ADDR_W+2:0] a1_r;
    logic [ADDR_W+2:0] a2_r;
    logic ck_d_r;
    logic ldqs_d_r;
    logic udqs_d_r;
    logic ck_s;
    logic cke_s;
    logic odt_s;
    logic ldqs_s;
    logic udqs_s;
    dllwl_cmd_t cmd_s;
    dllwl_addr_t addr_s;
    logic ck_rise;
    logic [2:0] cmd_code;
    logic cmd_valid;
    dllwl_pwr_t pwr_r;
    logic [3:0] stop_cnt_r;
    logic [3:0] al_r;
    logic [3:0] cl_r;
    logic [3:0] rd_cnt_r;
    logic rd_busy_r;
    logic [1:0] fb_r;
    logic sampled_r;

    function automatic logic [2:0] decode_cmd(input dllwl_cmd_t c);
        decode_cmd = {c.ras_n, c.cas_n, c.we_n};
    endfunction

    function automatic logic [3:0] read_start(input logic [3:0] al, input logic [3:0] cl,
                                               input logic off);
        read_start = off ? 4'(al + cl - 4'h1) : 4'(al + cl);
    endfunction

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s1_r <= '0;
            s2_r <= '0;
            a1_r <= '0;
            a2_r <= '0;
        end
        else
        begin
            s1_r <= {MEM_CK, MEM_CKE, MEM_ODT, MEM_LDQS, MEM_UDQS, MEM_CMD};
            s2_r <= s1_r;
            a1_r <= MEM_ADDR;
            a2_r <= a1_r;
        end
    end

    assign ck_s = s2_r[8];
    assign cke_s = s2_r[7];
    assign odt_s = s2_r[6];
    assign ldqs_s = s2_r[5];
    assign udqs_s = s2_r[4];
    assign cmd_s = s2_r[3:0];
    assign addr_s = a2_r;

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ck_d_r <= 1'b0;
            ldqs_d_r <= 1'b0;
            udqs_d_r <= 1'b0;
        end
        else
        begin
            ck_d_r <= ck_s;
            ldqs_d_r <= ldqs_s;
            udqs_d_r <= udqs_s;
        end
    end

    // clock edges count only while the device is not ignoring its clock
    assign ck_rise = ck_s && !ck_d_r && (pwr_r != ST_CLK_DONT_CARE);
    assign cmd_code = decode_cmd(cmd_s);
    // deselect and no-operation register nothing; commands need CKE high
    assign cmd_valid = ck_rise && !cmd_s.cs_n && (cmd_code != CMD_NO_OP)
                       && cke_s && (pwr_r == ST_IDLE);

    // power state tracking for self-refresh and precharge power-down
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pwr_r <= ST_IDLE;
            stop_cnt_r <= '0;
        end
        else
        begin
            case (pwr_r)
                ST_IDLE:
                begin
                    stop_cnt_r <= '0;
                    if (ck_rise && !cke_s)
                    begin
                        if (!cmd_s.cs_n && cmd_code == CMD_REF && !LEVEL_MODE)
                            pwr_r <= ST_SELF_REF;
                        else
                            pwr_r <= ST_POWER_DOWN;
                    end
                end
                ST_SELF_REF:
                begin
                    if (cke_s)
                        pwr_r <= ST_IDLE;
                    else if (ck_rise)
                    begin
                        if (stop_cnt_r >= CLK_STOP_CYC - 4'h1)
                            pwr_r <= ST_CLK_DONT_CARE;
                        else
                            stop_cnt_r <= stop_cnt_r + 4'h1;
                    end
                end
                ST_CLK_DONT_CARE:
                begin
                    // self-refresh exit is asynchronous to the clock
                    if (cke_s)
                        pwr_r <= ST_IDLE;
                end
                ST_POWER_DOWN:
                begin
                    if (ck_rise && cke_s)
                        pwr_r <= ST_IDLE;
                end
                default:
                    pwr_r <= ST_IDLE;
            endcase
        end
    end

    // mode register one and zero state
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            DLL_OFF <= 1'b0;
            LEVEL_MODE <= 1'b0;
            QOFF <= 1'b0;
            DLL_RESET <= 1'b0;
            al_r <= AL_RST;
            cl_r <= CL_RST;
        end
        else
        begin
            DLL_RESET <= 1'b0;
            if (cmd_valid && cmd_code == CMD_MRS)
            begin
                if (addr_s.bank == BA_MODE_ONE)
                begin
                    DLL_OFF <= addr_s.addr[MODE1_DLL_OFF_BIT];
                    LEVEL_MODE <= addr_s.addr[MODE1_LEVEL_BIT];
                    QOFF <= addr_s.addr[MODE1_QOFF_BIT];
                    al_r <= {2'h0, addr_s.addr[4:3]};
                end
                else if (addr_s.bank == BA_MODE_ZERO)
                begin
                    DLL_RESET <= addr_s.addr[MODE0_DLL_RESET_BIT];
                    cl_r <= 4'(addr_s.addr[6:4] + 3'h4);
                end
            end
        end
    end

    // DLL-off supports only one latency pair; CL is forced to six, AL still added
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            READ_LAT <= 4'(AL_RST + CL_RST);
        else
            READ_LAT <= read_start(al_r, DLL_OFF ? DLL_OFF_CL : cl_r, DLL_OFF);
    end

    // read strobe start counter in memory clock cycles
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rd_busy_r <= 1'b0;
            rd_cnt_r <= '0;
            READ_STROBE_START <= 1'b0;
        end
        else
        begin
            READ_STROBE_START <= 1'b0;
            if (cmd_valid && cmd_code == CMD_RD && !LEVEL_MODE)
            begin
                rd_busy_r <= 1'b1;
                rd_cnt_r <= 4'h1;
            end
            else if (rd_busy_r && ck_rise)
            begin
                if (rd_cnt_r == READ_LAT)
                begin
                    rd_busy_r <= 1'b0;
                    READ_STROBE_START <= 1'b1;
                end
                else
                    rd_cnt_r <= rd_cnt_r + 4'h1;
            end
        end
    end

    // termination: in leveling ODT only switches strobe termination
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            DQS_TERM_ON <= 1'b0;
            DQ_TERM_ON <= 1'b0;
        end
        else
        begin
            DQS_TERM_ON <= odt_s && (pwr_r == ST_IDLE);
            DQ_TERM_ON <= odt_s && !LEVEL_MODE && (pwr_r == ST_IDLE);
        end
    end

    // leveling feedback: each strobe rising edge samples the clock level
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            fb_r <= '0;
            sampled_r <= 1'b0;
        end
        else if (!LEVEL_MODE)
            sampled_r <= 1'b0;
        else
        begin
            if (ldqs_s && !ldqs_d_r)
            begin
                fb_r[0] <= ck_s;
                sampled_r <= 1'b1;
            end
            if (udqs_s && !udqs_d_r)
            begin
                fb_r[1] <= ck_s;
                sampled_r <= 1'b1;
            end
        end
    end

    // data pins: prime bit per lane carries feedback, rest driven low
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            DQ_OUT <= '0;
            DQ_OE_N <= '1;
        end
        else if (LEVEL_MODE && !QOFF && sampled_r)
        begin
            DQ_OUT <= '0;
            DQ_OUT[0] <= fb_r[0];
            DQ_OUT[LANE_W] <= fb_r[1];
            DQ_OE_N <= '0;
        end
        else
        begin
            DQ_OUT <= '0;
            DQ_OE_N <= '1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            CLK_IGNORED <= 1'b0;
        else
            CLK_IGNORED <= (pwr_r == ST_CLK_DONT_CARE);
    end
endmodule

// ==== dllwl_asserts.sv ====
/* Assertions on the outputs of dllwl_core, bound to it below.
   Assumes one CLK_SYS domain and ARST_N active low. */
`timescale 1ns/1ps
module dllwl_asserts
(
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic [dllwl_pkg::DQ_W-1:0] DQ_OUT,
    input wire logic [dllwl_pkg::DQ_W-1:0] DQ_OE_N,
    input wire logic DQS_TERM_ON,
    input wire logic DQ_TERM_ON,
    input wire logic DLL_OFF,
    input wire logic LEVEL_MODE,
    input wire logic DLL_RESET,
    input wire logic QOFF,
    input wire logic READ_STROBE_START,
    input wire logic CLK_IGNORED
);
    import dllwl_pkg::*;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!ARST_N);
    property p_qoff; QOFF && $past(QOFF) |-> &DQ_OE_N; endproperty
    a_qoff: assert property (p_qoff) else $error("dq driven while muted");
    property p_dqterm; LEVEL_MODE && $past(LEVEL_MODE) |-> !DQ_TERM_ON; endproperty
    a_dqterm: assert property (p_dqterm) else $error("dq term in leveling");
    property p_low; LEVEL_MODE |-> DQ_OUT[7:1] == 7'h00 && DQ_OUT[15:9] == 7'h00; endproperty
    a_low: assert property (p_low) else $error("non-prime dq high");
    property p_igterm; CLK_IGNORED |-> !DQS_TERM_ON && !DQ_TERM_ON; endproperty
    a_igterm: assert property (p_igterm) else $error("term on in self refresh");
    property p_ighold; CLK_IGNORED && $past(CLK_IGNORED) |-> $stable(DLL_OFF); endproperty
    a_ighold: assert property (p_ighold) else $error("mode changed in self refresh");
    property p_rstpls; DLL_RESET |=> !DLL_RESET; endproperty
    a_rstpls: assert property (p_rstpls) else $error("dll reset too long");
    property p_rdpls; READ_STROBE_START |=> !READ_STROBE_START [*4]; endproperty
    a_rdpls: assert property (p_rdpls) else $error("read start repeats");
    property p_igcke; $rose(CLK_IGNORED) |-> !$past(DQS_TERM_ON); endproperty
    a_igcke: assert property (p_igcke) else $error("strobe term on at clock stop");
endmodule
bind dllwl_core dllwl_asserts u_chk (.CLK_SYS, .ARST_N, .DQ_OUT, .DQ_OE_N,
    .DQS_TERM_ON, .DQ_TERM_ON, .DLL_OFF, .LEVEL_MODE, .DLL_RESET, .QOFF,
    .READ_STROBE_START, .CLK_IGNORED);

// ==== dllwl_ctrl_model.sv ====
/* Memory controller model driving the memory pins of dllwl_core.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
module dllwl_ctrl_model
(
    input wire logic clk,
    output logic mem_ck,
    output logic mem_cke,
    output dllwl_pkg::dllwl_cmd_t mem_cmd,
    output dllwl_pkg::dllwl_addr_t mem_addr,
    output logic mem_odt,
    output logic mem_ldqs,
    output logic mem_udqs
);
    import dllwl_pkg::*;
    logic run_r = 1'b1;
    initial
    begin
        mem_ck = 1'b0;
        mem_cke = 1'b1;
        mem_cmd = 4'hF;
        mem_addr = '0;
        mem_odt = 1'b0;
        mem_ldqs = 1'b0;
        mem_udqs = 1'b0;
    end
    always #160 if (run_r) mem_ck = ~mem_ck;
    // held across one link clock rise, then deselect and a scrambled bus
    task automatic issue(input dllwl_cmd_t c, input logic [2:0] b, input logic [13:0] a,
        input logic k);
        @(negedge mem_ck);
        @(negedge clk);
        mem_cmd = c;
        mem_addr = {b, a};
        mem_cke = k;
        @(negedge mem_ck);
        @(negedge clk);
        mem_cmd = 4'hF;
        mem_addr = ~mem_addr;
    endtask
    task automatic run(input logic r);
        if (!r)
            @(negedge mem_ck);
        run_r = r;
    endtask
    task automatic odt(input logic v);
        @(negedge clk);
        mem_odt = v;
    endtask
    // strobe rises dly ns after a link clock fall
    task automatic strobe(input logic up, input int dly);
        @(negedge mem_ck);
        #dly;
        @(negedge clk);
        if (up)
            mem_udqs = 1'b1;
        else
            mem_ldqs = 1'b1;
        repeat (2) @(negedge clk);
        mem_udqs = 1'b0;
        mem_ldqs = 1'b0;
    endtask
endmodule

// ==== dllwl_core_tb_top.sv ====
/* Self-checking bench for dllwl_core: mode register table, then read timing,
   self-refresh, power-down and leveling. Assumes dllwl_ctrl_model on the pins. */
`timescale 1ns/1ps
module dllwl_core_tb_top;
    import dllwl_pkg::*;
    typedef struct packed {
        dllwl_cmd_t c;
        logic [2:0] b;
        logic [13:0] a;
        logic [6:0] exp; // {dll off, leveling, qoff, read latency}
    } dllwl_row_t;
    localparam dllwl_cmd_t MRS = {1'b0, CMD_MRS};
    localparam dllwl_cmd_t DES = 4'hF;
    // stand-in for the DLL lock time, in system clock cycles
    localparam int LOCK_CYC = 64;
    localparam dllwl_row_t ROWS [8] = '{
        '{MRS, BA_MODE_ZERO, 14'h0020, 7'h06},
        '{MRS, BA_MODE_ONE, 14'h0001, 7'h45},
        '{DES, BA_MODE_ONE, 14'h0000, 7'h45},
        '{4'h7, BA_MODE_ONE, 14'h0000, 7'h45},
        '{MRS, BA_MODE_ONE, 14'h0000, 7'h06},
        '{MRS, BA_MODE_ONE, 14'h0080, 7'h26},
        '{MRS, BA_MODE_ONE, 14'h1080, 7'h36},
        '{MRS, BA_MODE_ONE, 14'h0000, 7'h06}};
    logic clk, arst_n, mem_ck, mem_cke, mem_odt, mem_ldqs, mem_udqs;
    dllwl_cmd_t mem_cmd;
    dllwl_addr_t mem_addr;
    logic [DQ_W-1:0] dq_out, dq_oe_n;
    logic dqs_term_on, dq_term_on, dll_off, level_mode, qoff, dll_reset, rd_start, clk_ign;
    logic [3:0] read_lat;
    logic [6:0] mode_v;
    assign mode_v = {dll_off, level_mode, qoff, read_lat};
    int error_cnt = 0, samples_checked = 0, cyc = 0, pulses = 0, f;
    dllwl_ctrl_model u_ctrl (.clk(clk), .mem_ck(mem_ck), .mem_cke(mem_cke), .mem_cmd(mem_cmd),
        .mem_addr(mem_addr), .mem_odt(mem_odt), .mem_ldqs(mem_ldqs), .mem_udqs(mem_udqs));
    dllwl_core DUT (.CLK_SYS(clk), .ARST_N(arst_n), .MEM_CK(mem_ck), .MEM_CKE(mem_cke),
        .MEM_CMD(mem_cmd), .MEM_ADDR(mem_addr), .MEM_ODT(mem_odt), .MEM_LDQS(mem_ldqs),
        .MEM_UDQS(mem_udqs), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .DQS_TERM_ON(dqs_term_on),
        .DQ_TERM_ON(dq_term_on), .DLL_OFF(dll_off), .LEVEL_MODE(level_mode), .QOFF(qoff),
        .DLL_RESET(dll_reset), .READ_LAT(read_lat), .READ_STROBE_START(rd_start),
        .CLK_IGNORED(clk_ign));
    task automatic test_done();
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // counts link clock rises between a read and its strobe start
    task automatic rd_chk(input int exp);
        int n;
        logic q;
        n = 0;
        u_ctrl.issue({1'b0, CMD_RD}, 3'h0, 14'h0000, 1'b1);
        q = mem_ck;
        for (int i = 0; i < 100 && rd_start !== 1'b1; i++)
        begin
            @(negedge clk);
            if (mem_ck && !q)
                n++;
            q = mem_ck;
        end
        chk(rd_start === 1'b1 && n == exp, "read strobe timing");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk)
    begin
        cyc++;
        if (dll_reset === 1'b1)
            pulses++;
        if (cyc == 8000)
        begin
            error_cnt++;
            test_done();
        end
    end
    initial
    begin
        arst_n = 1'b0;
        repeat (6) @(negedge clk);
        chk(dq_oe_n === '1 && mode_v === 7'h06, "reset");
        arst_n = 1'b1;
        foreach (ROWS[i])
        begin
            u_ctrl.issue(ROWS[i].c, ROWS[i].b, ROWS[i].a, 1'b1);
            chk(mode_v === ROWS[i].exp, "mode");
        end
        u_ctrl.issue(MRS, BA_MODE_ONE, 14'h0001, 1'b1);
        rd_chk(5);
        u_ctrl.issue({1'b0, CMD_REF}, 3'h0, 14'h0000, 1'b0);
        repeat (12) @(negedge clk);
        chk(clk_ign === 1'b1, "clock not ignored");
        u_ctrl.issue(MRS, BA_MODE_ONE, 14'h0000, 1'b0);
        u_ctrl.run(1'b0);
        repeat (30) @(negedge clk);
        u_ctrl.run(1'b1);
        u_ctrl.issue(DES, 3'h0, 14'h0000, 1'b1);
        chk(clk_ign === 1'b0 && dll_off === 1'b1, "self refresh");
        u_ctrl.issue(MRS, BA_MODE_ZERO, 14'h0020, 1'b1);
        u_ctrl.issue(MRS, BA_MODE_ONE, 14'h0000, 1'b1);
        u_ctrl.issue(MRS, BA_MODE_ZERO, 14'h0120, 1'b1);
        chk(pulses == 1 && dll_off === 1'b0, "dll reset");
        repeat (LOCK_CYC) @(negedge clk);
        rd_chk(6);
        u_ctrl.issue(DES, 3'h0, 14'h0000, 1'b0);
        u_ctrl.issue(MRS, BA_MODE_ONE, 14'h0001, 1'b0);
        u_ctrl.run(1'b0);
        repeat (10) @(negedge clk);
        u_ctrl.run(1'b1);
        u_ctrl.issue(DES, 3'h0, 14'h0000, 1'b1);
        chk(dll_off === 1'b0, "power down");
        u_ctrl.issue(MRS, BA_MODE_ZERO, 14'h0120, 1'b1);
        chk(pulses == 2, "power down dll reset");
        u_ctrl.issue(MRS, BA_MODE_ONE, 14'h0080, 1'b1);
        u_ctrl.odt(1'b1);
        repeat (4) @(negedge clk);
        chk(dqs_term_on === 1'b1 && dq_term_on === 1'b0, "odt");
        f = -1;
        for (int d = 0; d < 8 && f < 0; d++)
        begin
            u_ctrl.strobe(1'b0, d * 40);
            repeat (4) @(negedge clk);
            if (dq_out[0] === 1'b1)
                f = d;
        end
        chk(f >= 3 && f <= 5 && dq_oe_n[0] === 1'b0, "sweep");
        u_ctrl.strobe(1'b1, 200);
        u_ctrl.strobe(1'b0, 40);
        repeat (4) @(negedge clk);
        chk(dq_out[8] === 1'b1 && dq_out[0] === 1'b0, "lanes");
        u_ctrl.odt(1'b0);
        u_ctrl.issue(MRS, BA_MODE_ONE, 14'h1080, 1'b1);
        chk(dqs_term_on === 1'b0 && dq_oe_n === '1, "muted");
        u_ctrl.issue(MRS, BA_MODE_ONE, 14'h0000, 1'b1);
        chk(level_mode === 1'b0, "leveling exit");
        test_done();
    end
endmodule
